// ===== verilog/pbf_defines.vh
// Function
// - host writes bytes like a fast printer port; each accepted byte is buffered
// - accepted bytes stay in external ram until the printer can take them
// - stored bytes go to the printer as fast as accepted until empty
// - draining to the printer runs on its own without host action
// - host reads full and busy status before writes to avoid overflow
// - printer side senses ack and busy and answers before next data
// - queue in external static ram holds up to 64k minus one bytes
// - two independent 16-bit pointers: read pointer and store pointer
// - pointers compared continuously to decide full and empty
// - pointers multiplexed onto one 16-bit ram address bus, one at a time
// - host write strobe captures host data into first input register
// - first register moves synchronously into second register before ram write
// - bytes read from ram captured in third register, driven to printer outputs
// - ram data bus driven for writes half the time, released for reads otherwise
// - controller generates ram select and write strobe, owning ram timing
// - host port has chip select, read/write and eight-bit data bus
// - printer port has data strobe, eight data outputs, busy and ack inputs
// - single 100 mhz system clock and master reset drive all logic
// - on initialization read pointer equals store pointer, queue empty
// - empty when pointers equal, full when store plus one equals read
// - pointers increment after access and wrap modulo memory size
`ifndef PBF_DEFINES_VH
`define PBF_DEFINES_VH
// ==========================================
// widths
`define PBF_ADDR_W      16
`define PBF_DATA_W      8
// ==========================================
// timing generator: 8 states, writes in 0..3, reads in 4..7
`define PBF_PHASE_W     3
`define PBF_WE_ON       3'h1
`define PBF_WE_OFF      3'h3
`define PBF_WR_LAST     3'h3
`define PBF_RD_SAMPLE   3'h6
`define PBF_RD_LAST     3'h7
// ==========================================
// printer strobe timing in ns, at 10 ns clock
`define PBF_CLK_NS      10
`define PBF_SETUP_NS    500
`define PBF_STROBE_NS   500
`define PBF_HOLD_NS     500
`define PBF_SETUP_CYC   ((`PBF_SETUP_NS + `PBF_CLK_NS - 1) / `PBF_CLK_NS)
`define PBF_STROBE_CYC  ((`PBF_STROBE_NS + `PBF_CLK_NS - 1) / `PBF_CLK_NS)
`define PBF_HOLD_CYC    ((`PBF_HOLD_NS + `PBF_CLK_NS - 1) / `PBF_CLK_NS)
`define PBF_CNT_W       8
// ==========================================
// status byte layout
`define PBF_ST_FULL     0
`define PBF_ST_BUSY     1
`define PBF_ST_READY    2
`define PBF_ST_EMPTY    3
`endif

// ===== verilog/pbf_printer_port.v
`timescale 1ns/1ps
`default_nettype none
`include "pbf_defines.vh"
module pbf_printer_port #(
  parameter SETUP_CYC  = `PBF_SETUP_CYC,
  parameter STROBE_CYC = `PBF_STROBE_CYC,
  parameter HOLD_CYC   = `PBF_HOLD_CYC
) (
  input  wire                   ref_clk,
  input  wire                   rst,
  input  wire                   byte_valid,
  input  wire [`PBF_DATA_W-1:0] byte_in,
  output wire                   byte_taken,
  input  wire                   printer_busy,
  input  wire                   printer_ack_n,
  output reg  [`PBF_DATA_W-1:0] printer_data_out_ff,
  output reg                    printer_data_strobe_n_ff,
  output wire                   port_busy
);
  // ==========================================
  // states
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_SETUP = 5'h02;
  localparam [4:0] S_STRB  = 5'h04;
  localparam [4:0] S_HOLD  = 5'h08;
  localparam [4:0] S_ACK   = 5'h10;

  reg [4:0]            state_ff;
  reg [4:0]            nxt_state;
  reg [`PBF_CNT_W-1:0] cnt_ff;
  reg [`PBF_CNT_W-1:0] nxt_cnt;
  reg                  ack_seen_ff;

  assign byte_taken = state_ff[0] & byte_valid & ~printer_busy;
  assign port_busy  = ~state_ff[0];

  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 8'h01;
    case (state_ff)
      S_IDLE: begin
        nxt_cnt = 8'h00;
        if (byte_taken)
          nxt_state = S_SETUP;
      end
      S_SETUP: begin
        if (cnt_ff == SETUP_CYC[`PBF_CNT_W-1:0] - 8'h01) begin
          nxt_state = S_STRB;
          nxt_cnt   = 8'h00;
        end
      end
      S_STRB: begin
        if (cnt_ff == STROBE_CYC[`PBF_CNT_W-1:0] - 8'h01) begin
          nxt_state = S_HOLD;
          nxt_cnt   = 8'h00;
        end
      end
      S_HOLD: begin
        if (cnt_ff == HOLD_CYC[`PBF_CNT_W-1:0] - 8'h01) begin
          nxt_state = S_ACK;
          nxt_cnt   = 8'h00;
        end
      end
      S_ACK: begin
        // next byte only after the printer acknowledged and dropped busy
        nxt_cnt = 8'h00;
        if ((ack_seen_ff | ~printer_ack_n) & ~printer_busy)
          nxt_state = S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state_ff                 <= S_IDLE;
      cnt_ff                   <= 8'h00;
      ack_seen_ff              <= 1'b0;
      printer_data_out_ff      <= 8'h00;
      printer_data_strobe_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (byte_taken)
        printer_data_out_ff <= byte_in;
      printer_data_strobe_n_ff <= ~nxt_state[2];
      // ack pulse may come during strobe or hold; remember it
      if (state_ff[0])
        ack_seen_ff <= 1'b0;
      else if (~printer_ack_n)
        ack_seen_ff <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/pbf_controller.v
`timescale 1ns/1ps
`default_nettype none
`include "pbf_defines.vh"
module pbf_controller #(
  parameter ADDR_W     = `PBF_ADDR_W,
  parameter SETUP_CYC  = `PBF_SETUP_CYC,
  parameter STROBE_CYC = `PBF_STROBE_CYC,
  parameter HOLD_CYC   = `PBF_HOLD_CYC
) (
  input  wire                   ref_clk,
  input  wire                   rst,
  input  wire                   host_cs_n,
  input  wire                   host_rd_wr_n,
  input  wire                   host_wr_strobe_n,
  input  wire [`PBF_DATA_W-1:0] host_data_bus_in,
  output reg  [`PBF_DATA_W-1:0] host_data_bus_out_ff,
  output reg                    host_data_bus_oe_n_ff,
  output reg  [ADDR_W-1:0]      ram_address_bus_ff,
  input  wire [`PBF_DATA_W-1:0] ram_data_bus_in,
  output reg  [`PBF_DATA_W-1:0] ram_data_bus_out_ff,
  output reg                    ram_data_bus_oe_n_ff,
  output reg                    ram_select_n_ff,
  output reg                    ram_write_strobe_n_ff,
  output reg  [`PBF_DATA_W-1:0] printer_data_out_ff,
  output reg                    printer_data_strobe_n_ff,
  input  wire                   printer_busy,
  input  wire                   printer_ack_n
);
  // ==========================================
  // pointer arithmetic, modulo 2^ADDR_W
  function [ADDR_W-1:0] ptr_inc;
    input [ADDR_W-1:0] p;
    begin
      ptr_inc = p + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // ==========================================
  // state
  reg [`PBF_PHASE_W-1:0] phase_ff;
  reg [ADDR_W-1:0]       store_ptr_ff;
  reg [ADDR_W-1:0]       read_ptr_ff;
  reg [`PBF_DATA_W-1:0]  reg1_ff;
  reg                    reg1_full_ff;
  reg                    reg1_sync_ff;
  reg [`PBF_DATA_W-1:0]  reg2_ff;
  reg                    reg2_full_ff;
  reg                    wr_req_ff;
  reg                    rd_cycle_ff;
  reg [`PBF_DATA_W-1:0]  reg3_ff;
  reg                    reg3_full_ff;
  reg                    strobe_d_ff;
  wire                   q_empty;
  wire                   q_full;
  wire                   wr_edge;
  wire                   host_read;
  wire                   reg3_taken;
  wire                   port_busy;
  wire [`PBF_DATA_W-1:0] port_data;
  wire                   port_strobe_n;
  wire                   busy_flag;
  wire [`PBF_PHASE_W-1:0] phase_next;
  wire                   wr_start;
  wire                   wr_drive;
  wire                   rd_start;
  wire                   rd_drive;
  wire                   we_on;

  // ==========================================
  // queue flags, combinational off both pointers
  assign q_empty = (read_ptr_ff == store_ptr_ff);
  assign q_full  = (ptr_inc(store_ptr_ff) == read_ptr_ff);

  // host write latches on the rising edge of the strobe
  assign wr_edge   = ~host_cs_n & ~host_rd_wr_n & host_wr_strobe_n & ~strobe_d_ff;
  assign host_read = ~host_cs_n & host_rd_wr_n;
  assign busy_flag = ~q_empty | reg1_full_ff | reg2_full_ff | reg3_full_ff | port_busy;

  // ==========================================
  // slot decodes: pins are registered, so each one is taken a phase early
  assign phase_next = phase_ff + 3'h1;
  // a write is requested only before a whole write slot, never part way in
  assign wr_start   = (phase_ff == `PBF_RD_LAST) & reg2_full_ff & ~q_full;
  assign wr_drive   = wr_start | (wr_req_ff & ~phase_ff[2] & (phase_ff != `PBF_WR_LAST));
  assign rd_start   = (phase_ff == `PBF_WR_LAST) & ~q_empty & ~reg3_full_ff;
  assign rd_drive   = rd_start | (rd_cycle_ff & phase_ff[2] & (phase_ff != `PBF_RD_LAST));
  assign we_on      = wr_req_ff & ((phase_ff == 3'h0) | (phase_ff == `PBF_WE_ON));

  // ==========================================
  // timing generator: free-running 8 states
  always @(posedge ref_clk) begin
    if (rst)
      phase_ff <= 3'h0;
    else
      phase_ff <= phase_ff + 3'h1;
  end

  // ==========================================
  // host side two-stage input fifo
  always @(posedge ref_clk) begin
    if (rst) begin
      strobe_d_ff  <= 1'b1;
      reg1_ff      <= 8'h00;
      reg1_full_ff <= 1'b0;
      reg1_sync_ff <= 1'b0;
      reg2_ff      <= 8'h00;
      reg2_full_ff <= 1'b0;
    end else begin
      strobe_d_ff  <= host_wr_strobe_n | host_cs_n | host_rd_wr_n;
      reg1_sync_ff <= reg1_full_ff;
      // a write while reg1 still holds a byte is the host ignoring ready; dropped
      if (wr_edge & ~reg1_full_ff) begin
        reg1_ff      <= host_data_bus_in;
        reg1_full_ff <= 1'b1;
      end else if (reg1_sync_ff & reg1_full_ff & ~reg2_full_ff) begin
        reg1_full_ff <= 1'b0;
      end
      if (reg1_sync_ff & reg1_full_ff & ~reg2_full_ff) begin
        reg2_ff      <= reg1_ff;
        reg2_full_ff <= 1'b1;
      end else if (wr_req_ff & (phase_ff == `PBF_WR_LAST)) begin
        reg2_full_ff <= 1'b0;
      end
    end
  end

  // ==========================================
  // ram slot control
  always @(posedge ref_clk) begin
    if (rst) begin
      store_ptr_ff <= {ADDR_W{1'b0}};
      read_ptr_ff  <= {ADDR_W{1'b0}};
      wr_req_ff    <= 1'b0;
      rd_cycle_ff  <= 1'b0;
      reg3_ff      <= 8'h00;
      reg3_full_ff <= 1'b0;
    end else begin
      // request only at the edge before a write slot, so no slot is cut short
      if (wr_start)
        wr_req_ff <= 1'b1;
      else if (wr_req_ff && phase_ff == `PBF_WR_LAST) begin
        wr_req_ff    <= 1'b0;
        store_ptr_ff <= ptr_inc(store_ptr_ff);
      end
      // read slot only when the queue holds data and reg3 has room
      if (rd_start)
        rd_cycle_ff <= 1'b1;
      else if (rd_cycle_ff && phase_ff == `PBF_RD_LAST) begin
        rd_cycle_ff <= 1'b0;
        read_ptr_ff <= ptr_inc(read_ptr_ff);
      end
      if (rd_cycle_ff && phase_ff == `PBF_RD_SAMPLE) begin
        reg3_ff      <= ram_data_bus_in;
        reg3_full_ff <= 1'b1;
      end else if (reg3_taken) begin
        reg3_full_ff <= 1'b0;
      end
    end
  end

  // ==========================================
  // ram pins, all registered
  always @(posedge ref_clk) begin
    if (rst) begin
      ram_address_bus_ff    <= {ADDR_W{1'b0}};
      ram_data_bus_out_ff   <= 8'h00;
      ram_data_bus_oe_n_ff  <= 1'b1;
      ram_select_n_ff       <= 1'b1;
      ram_write_strobe_n_ff <= 1'b1;
    end else begin
      // one pointer on the bus at a time; pins lag a clock, so pick by the next phase
      if (phase_next[2])
        ram_address_bus_ff <= read_ptr_ff;
      else
        ram_address_bus_ff <= store_ptr_ff;
      ram_data_bus_out_ff   <= reg2_ff;
      // drive only during the write half
      ram_data_bus_oe_n_ff  <= ~wr_drive;
      ram_select_n_ff       <= ~(wr_drive | rd_drive);
      // strobe low for states 1 and 2 of the write slot for setup and hold margin
      ram_write_strobe_n_ff <= ~we_on;
    end
  end

  // ==========================================
  // host status read, no side effects
  always @(posedge ref_clk) begin
    if (rst) begin
      host_data_bus_out_ff  <= 8'h00;
      host_data_bus_oe_n_ff <= 1'b1;
    end else begin
      host_data_bus_oe_n_ff <= ~host_read;
      host_data_bus_out_ff  <= 8'h00;
      host_data_bus_out_ff[`PBF_ST_FULL]  <= q_full;
      host_data_bus_out_ff[`PBF_ST_BUSY]  <= busy_flag;
      host_data_bus_out_ff[`PBF_ST_READY] <= ~reg1_full_ff;
      host_data_bus_out_ff[`PBF_ST_EMPTY] <= q_empty;
    end
  end

  // ==========================================
  // printer handshake
  pbf_printer_port #(
    .SETUP_CYC  (SETUP_CYC),
    .STROBE_CYC (STROBE_CYC),
    .HOLD_CYC   (HOLD_CYC)
  ) u_port (
    .ref_clk                  (ref_clk),
    .rst                      (rst),
    .byte_valid               (reg3_full_ff),
    .byte_in                  (reg3_ff),
    .byte_taken               (reg3_taken),
    .printer_busy             (printer_busy),
    .printer_ack_n            (printer_ack_n),
    .printer_data_out_ff      (port_data),
    .printer_data_strobe_n_ff (port_strobe_n),
    .port_busy                (port_busy)
  );

  // top outputs come from flip-flops; re-register the port pins
  always @(posedge ref_clk) begin
    if (rst) begin
      printer_data_out_ff      <= 8'h00;
      printer_data_strobe_n_ff <= 1'b1;
    end else begin
      printer_data_out_ff      <= port_data;
      printer_data_strobe_n_ff <= port_strobe_n;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/pbf_controller_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pbf_controller_asserts #(
  parameter ADDR_W     = 16,
  parameter STROBE_CYC = 50
) (
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic              host_cs_n,
  input wire logic              host_rd_wr_n,
  input wire logic              host_wr_strobe_n,
  input wire logic [7:0]        host_data_bus_in,
  input wire logic [7:0]        host_data_bus_out_ff,
  input wire logic              host_data_bus_oe_n_ff,
  input wire logic [ADDR_W-1:0] ram_address_bus_ff,
  input wire logic [7:0]        ram_data_bus_in,
  input wire logic [7:0]        ram_data_bus_out_ff,
  input wire logic              ram_data_bus_oe_n_ff,
  input wire logic              ram_select_n_ff,
  input wire logic              ram_write_strobe_n_ff,
  input wire logic [7:0]        printer_data_out_ff,
  input wire logic              printer_data_strobe_n_ff,
  input wire logic              printer_busy,
  input wire logic              printer_ack_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // helpers: strobe length and expected store address
  logic [7:0]        stb_cnt_ff;
  logic [ADDR_W-1:0] wr_exp_ff;
  logic              wr_seen_ff;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stb_cnt_ff <= 8'h00;
      wr_seen_ff <= 1'b0;
      wr_exp_ff  <= '0;
    end else begin
      stb_cnt_ff <= printer_data_strobe_n_ff ? 8'h00 : stb_cnt_ff + 8'h01;
      if ($fell(ram_write_strobe_n_ff)) begin
        wr_seen_ff <= 1'b1;
        wr_exp_ff  <= ram_address_bus_ff + 1'b1;
      end
    end
  end
  // ==========================================
  // assertions
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> ram_select_n_ff
    && ram_write_strobe_n_ff && printer_data_strobe_n_ff) else $error("strobes active after reset");
  a_status_drive: assert property (!host_cs_n && host_rd_wr_n |=> !host_data_bus_oe_n_ff
    && host_data_bus_out_ff[7:4] == 4'h0) else $error("status not driven");
  a_status_release: assert property (host_cs_n |=> host_data_bus_oe_n_ff)
    else $error("host bus driven without select");
  a_we_in_slot: assert property (!ram_write_strobe_n_ff |-> !ram_select_n_ff
    && !ram_data_bus_oe_n_ff) else $error("ram write outside driven slot");
  a_we_width: assert property ($fell(ram_write_strobe_n_ff) |=> !ram_write_strobe_n_ff
    ##1 ram_write_strobe_n_ff) else $error("ram write strobe width");
  a_we_stable: assert property (!ram_write_strobe_n_ff && !$fell(ram_write_strobe_n_ff)
    |-> $stable(ram_address_bus_ff) && $stable(ram_data_bus_out_ff)) else $error("ram moved in write");
  a_store_step: assert property ($fell(ram_write_strobe_n_ff) && wr_seen_ff
    |-> ram_address_bus_ff == wr_exp_ff) else $error("store address did not step by one");
  a_strobe_width: assert property ($rose(printer_data_strobe_n_ff)
    |-> stb_cnt_ff == STROBE_CYC) else $error("printer strobe width");
  a_strobe_data: assert property (!printer_data_strobe_n_ff |-> $stable(printer_data_out_ff))
    else $error("printer data moved under strobe");
  c_ram_write: cover property ($fell(ram_write_strobe_n_ff));
  c_print: cover property ($rose(printer_data_strobe_n_ff));
  c_status: cover property (!host_cs_n && host_rd_wr_n);
endmodule
bind pbf_controller pbf_controller_asserts #(.ADDR_W(ADDR_W), .STROBE_CYC(STROBE_CYC)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .host_cs_n(host_cs_n), .host_rd_wr_n(host_rd_wr_n),
  .host_wr_strobe_n(host_wr_strobe_n), .host_data_bus_in(host_data_bus_in),
  .host_data_bus_out_ff(host_data_bus_out_ff), .host_data_bus_oe_n_ff(host_data_bus_oe_n_ff),
  .ram_address_bus_ff(ram_address_bus_ff), .ram_data_bus_in(ram_data_bus_in),
  .ram_data_bus_out_ff(ram_data_bus_out_ff), .ram_data_bus_oe_n_ff(ram_data_bus_oe_n_ff),
  .ram_select_n_ff(ram_select_n_ff), .ram_write_strobe_n_ff(ram_write_strobe_n_ff),
  .printer_data_out_ff(printer_data_out_ff), .printer_data_strobe_n_ff(printer_data_strobe_n_ff),
  .printer_busy(printer_busy), .printer_ack_n(printer_ack_n));
`default_nettype wire

// ===== testbench/pbf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbf_host_model (
  input  wire logic       ref_clk,
  output var  logic       host_cs_n,
  output var  logic       host_rd_wr_n,
  output var  logic       host_wr_strobe_n,
  output var  logic [7:0] host_data_bus_in,
  input  wire logic [7:0] host_data_bus_out_ff,
  input  wire logic       host_data_bus_oe_n_ff
);
  initial begin
    host_cs_n = 1'b1;
    host_rd_wr_n = 1'b1;
    host_wr_strobe_n = 1'b1;
    host_data_bus_in = 8'h00;
  end
  // ==========================================
  // status answers one cycle after select
  task automatic read_status(output logic [7:0] st, output logic oe_n);
    @(negedge ref_clk);
    host_cs_n = 1'b0;
    host_rd_wr_n = 1'b1;
    @(negedge ref_clk);
    st = host_data_bus_out_ff;
    oe_n = host_data_bus_oe_n_ff;
    host_cs_n = 1'b1;
  endtask
  // polls ready first; a write while not ready would be dropped
  task automatic write_byte(input logic [7:0] b);
    logic [7:0] st;
    logic       oe_n;
    int         k;
    st = 8'h00;
    for (k = 0; k < 400 && st[2] !== 1'b1; k++) read_status(st, oe_n);
    @(negedge ref_clk);
    host_cs_n = 1'b0;
    host_rd_wr_n = 1'b0;
    host_data_bus_in = b;
    host_wr_strobe_n = 1'b0;
    @(negedge ref_clk);
    host_wr_strobe_n = 1'b1;
    @(negedge ref_clk);
    host_cs_n = 1'b1;
    host_rd_wr_n = 1'b1;
    host_data_bus_in = ~b; // released bus shows no stale byte
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int AW = 4;
  logic          ref_clk, rst, cs_n, rw_n, wstb_n, hoe_n, roe_n, sel_n, we_n, pstb_n;
  logic          printer_busy, printer_ack_n, stb_q, hold_busy, oe;
  logic [7:0]    hin, hout, rin, rout, pdata, st;
  logic [AW-1:0] addr;
  logic [7:0]    mem [0:15];
  logic [7:0]    exp_q [$];
  int            fail_count, tests_run, cyc, stall, pend, n, i;
  pbf_controller #(.ADDR_W(AW), .SETUP_CYC(2), .STROBE_CYC(2), .HOLD_CYC(4)) u_pbf_controller (
    .ref_clk(ref_clk), .rst(rst), .host_cs_n(cs_n), .host_rd_wr_n(rw_n),
    .host_wr_strobe_n(wstb_n), .host_data_bus_in(hin), .host_data_bus_out_ff(hout),
    .host_data_bus_oe_n_ff(hoe_n), .ram_address_bus_ff(addr), .ram_data_bus_in(rin),
    .ram_data_bus_out_ff(rout), .ram_data_bus_oe_n_ff(roe_n), .ram_select_n_ff(sel_n),
    .ram_write_strobe_n_ff(we_n), .printer_data_out_ff(pdata),
    .printer_data_strobe_n_ff(pstb_n), .printer_busy(printer_busy),
    .printer_ack_n(printer_ack_n));
  pbf_host_model u_pbf_host_model (
    .ref_clk(ref_clk), .host_cs_n(cs_n), .host_rd_wr_n(rw_n), .host_wr_strobe_n(wstb_n),
    .host_data_bus_in(hin), .host_data_bus_out_ff(hout), .host_data_bus_oe_n_ff(hoe_n));
  // ==========================================
  // clock, sram model, printer model
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // unselected or write slot: data lines toggle so no stale byte is read
  assign rin = (!sel_n && roe_n) ? mem[addr] : cyc[7:0];
  always @(posedge ref_clk) if (!sel_n && !we_n) mem[addr] <= rout;
  always @(negedge ref_clk) begin
    if (stb_q && !pstb_n) begin
      check(exp_q.size() != 0 && pdata === exp_q[0], "printed byte");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    printer_ack_n = stb_q || !pstb_n;
    if (!stb_q && pstb_n) pend = $urandom_range(stall, 0);
    else if (pend > 0) pend = pend - 1;
    printer_busy = hold_busy || !pstb_n || pend > 0;
    stb_q = pstb_n;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      fail_count++;
      $display("wrong value at %0t: run hung", $time);
      wrap_up();
    end
  end
  // ==========================================
  // tasks
  task automatic check(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // status byte as the host should see it: bit0 full, bit1 busy, bit2 ready, bit3 empty
  function automatic logic [7:0] exp_status(input bit full, input bit busy, input bit rdy,
                                            input bit empty);
    return {4'h0, empty, rdy, busy, full};
  endfunction
  task automatic send(input logic [7:0] b);
    exp_q.push_back(b);
    u_pbf_host_model.write_byte(b);
  endtask
  task automatic drain();
    int k;
    for (k = 0; k < 3000 && (exp_q.size() != 0 || st !== exp_status(0, 0, 1, 1)); k++)
      u_pbf_host_model.read_status(st, oe);
    check(exp_q.size() == 0 && st === exp_status(0, 0, 1, 1) && oe === 1'b0, "drained");
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    printer_busy = 1'b0;
    printer_ack_n = 1'b1;
    hold_busy = 1'b0;
    stb_q = 1'b1;
    stall = 0;
    pend = 0;
    cyc = 0;
    fail_count = 0;
    tests_run = 0;
    void'($urandom(32'h2badd982));
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    u_pbf_host_model.read_status(st, oe);
    check(st === exp_status(0, 0, 1, 1) && oe === 1'b0, "idle status after reset");
    // corner bytes, then random traffic past the pointer wrap
    stall = 20;
    send(8'h00);
    send(8'hff);
    for (i = 0; i < 40; i++) send(8'($urandom));
    u_pbf_host_model.read_status(st, oe);
    check(st[1] === 1'b1 && st[3] === 1'b0, "busy while printing");
    drain();
    // printer held off: queue fills, nothing is lost
    hold_busy = 1'b1;
    n = 0;
    do begin
      send(8'(n) ^ 8'ha5);
      n++;
      u_pbf_host_model.read_status(st, oe);
    end while (st[0] !== 1'b1 && n < 40);
    check(n >= 15 && n <= 18, "full after capacity");
    hold_busy = 1'b0;
    drain();
    wrap_up();
  end
endmodule
`default_nettype wire
